// ===== include/rbt_pkg.sv
// shared constants, types and decode function for the registered transceiver
package rbt_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;
   localparam int BUS_W  = 32;
   localparam int CNT_W  = 16;

   typedef enum logic [1:0] {
      RBT_BUF   = 2'h0,
      RBT_FF    = 2'h1,
      RBT_LATCH = 2'h3
   } rbt_mode_e;

   // register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
   localparam logic [ADDR_W-1:0] COUNT_OFS  = 4'h8;

   // control fields and reset value
   localparam int CTRL_W              = 2;
   localparam int CTRL_BP_RELEASE_BIT = 0;
   localparam int CTRL_CARD_OFF_BIT   = 1;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

   // status fields
   localparam int ST_TX_LSB     = 0;
   localparam int ST_RX_LSB     = 8;
   localparam int ST_TXMODE_LSB = 16;
   localparam int ST_RXMODE_LSB = 18;
   localparam int ST_FB_BIT     = 20;
   localparam int ST_CARDOE_BIT = 21;
   localparam int ST_BPOE_BIT   = 22;

   // capture counter fields
   localparam int CNT_TX_LSB = 0;
   localparam int CNT_RX_LSB = 16;

   function automatic rbt_mode_e rbt_decode_mode(input logic selHi, input logic selLo);
      if (selHi)
         rbt_decode_mode = RBT_LATCH;
      else if (selLo)
         rbt_decode_mode = RBT_FF;
      else
         rbt_decode_mode = RBT_BUF;
   endfunction : rbt_decode_mode
endpackage : rbt_pkg

// ===== core/rbt_elem.sv
// one direction's logic element: buffer, rising-edge flip-flop or gated latch
`timescale 1ns/1ps
module rbt_elem (
   // clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      sys_rst,
   // configuration
   input  wire rbt_pkg::rbt_mode_e        mode,
   input  wire logic                      gateIn,
   // data
   input  wire logic [rbt_pkg::DATA_W-1:0] dataIn,
   output logic      [rbt_pkg::DATA_W-1:0] elemOut,
   output logic                           capturePulse
);
   import rbt_pkg::*;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   logic              gatePrev_ff;
   logic [DATA_W-1:0] store_ff;
   logic [DATA_W-1:0] nxt_store;

   wire isBuf      = (mode == RBT_BUF);
   wire isFf       = (mode == RBT_FF);
   wire isLatch    = (mode == RBT_LATCH);
   wire risingEdge = gateIn & ~gatePrev_ff;
   wire captureNow = (isFf & risingEdge) | (isLatch & gateIn);

   assign nxt_store    = captureNow ? dataIn : store_ff;
   assign capturePulse = isFf & risingEdge;
   // latch is open while the gate is high, buffer never stores
   assign elemOut = (isBuf | (isLatch & gateIn)) ? dataIn : store_ff;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         gatePrev_ff <= 1'b0;
      else
         gatePrev_ff <= gateIn;
   end

   // data storage deliberately has no reset
   always_ff @(posedge ref_clk)
   begin
      store_ff <= nxt_store;
   end

   property p_buf_pass;
      isBuf |-> (elemOut == dataIn);
   endproperty
   a_buf_pass: assert property (p_buf_pass) else $error("buffer output differs from input");

   property p_ff_capture;
      (isFf && gateIn && !gatePrev_ff) |=> (store_ff == $past(dataIn));
   endproperty
   a_ff_capture: assert property (p_ff_capture) else $error("flip-flop missed rising-edge capture");

   property p_ff_hold;
      (isFf && !(gateIn && !gatePrev_ff)) |=> $stable(store_ff);
   endproperty
   a_ff_hold: assert property (p_ff_hold) else $error("flip-flop changed without rising edge");

   property p_latch_open;
      (isLatch && gateIn) |-> (elemOut == dataIn);
   endproperty
   a_latch_open: assert property (p_latch_open) else $error("open latch not transparent");

   property p_latch_hold;
      (isLatch && !gateIn) [*2] |-> (elemOut == $past(elemOut));
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("closed latch did not hold");
endmodule : rbt_elem

// ===== core/rbt_regs.sv
// avalon-mm register slave: control, status and capture counters
`timescale 1ns/1ps
module rbt_regs (
   // clock and reset
   input  wire logic                         ref_clk,
   input  wire logic                         sys_rst,
   // avalon-mm slave
   input  wire logic [rbt_pkg::ADDR_W-1:0]   avs_address,
   input  wire logic                         avs_read,
   input  wire logic                         avs_write,
   input  wire logic [rbt_pkg::BUS_W-1:0]    avs_writedata,
   output logic      [rbt_pkg::BUS_W-1:0]    avs_readdata,
   output logic                              avs_waitrequest,
   // block side
   input  wire logic [rbt_pkg::BUS_W-1:0]    statusWord,
   input  wire logic [rbt_pkg::BUS_W-1:0]    countWord,
   output logic      [rbt_pkg::CTRL_W-1:0]   ctrlBits,
   output logic                              countClear
);
   import rbt_pkg::*;

   logic              ack_ff;
   logic [BUS_W-1:0]  readdata_ff;
   logic [CTRL_W-1:0] ctrl_ff;

   wire reqActive = avs_read | avs_write;
   wire firstCyc  = reqActive & ~ack_ff;
   wire accept    = reqActive & ack_ff;
   wire hitCtrl   = (avs_address == CTRL_OFS);
   wire hitStatus = (avs_address == STATUS_OFS);
   wire hitCount  = (avs_address == COUNT_OFS);
   // unmapped offsets read zero and ignore writes
   wire [BUS_W-1:0] readSel = hitCtrl   ? {{(BUS_W-CTRL_W){1'b0}}, ctrl_ff} :
                              hitStatus ? statusWord :
                              hitCount  ? countWord : 32'h0;

   // one wait state gives time to register read data
   assign avs_waitrequest = firstCyc;
   assign avs_readdata    = readdata_ff;
   assign ctrlBits        = ctrl_ff;
   assign countClear      = accept & avs_write & hitCount;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         ack_ff      <= 1'b0;
         readdata_ff <= 32'h0;
         ctrl_ff     <= CTRL_RESET;
      end
      else
      begin
         ack_ff <= firstCyc;
         if (firstCyc & avs_read)
            readdata_ff <= readSel;
         if (accept & avs_write & hitCtrl)
            ctrl_ff <= avs_writedata[CTRL_W-1:0];
      end
   end
endmodule : rbt_regs

// ===== core/rbt_top.sv
// eight-bit inverting registered transceiver with feedback path
//
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module rbt_top (
   // clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       sys_rst,
   // avalon-mm slave
   input  wire logic [rbt_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [rbt_pkg::BUS_W-1:0]  avs_writedata,
   output logic      [rbt_pkg::BUS_W-1:0]  avs_readdata,
   output logic                            avs_waitrequest,
   // card side
   input  wire logic [rbt_pkg::DATA_W-1:0] cardSideInput,
   output logic      [rbt_pkg::DATA_W-1:0] cardSideOutput,
   output logic                            cardSideOutputOe,
   // backplane port
   input  wire logic [rbt_pkg::DATA_W-1:0] backplaneIn,
   output logic      [rbt_pkg::DATA_W-1:0] backplaneOut,
   output logic                            backplaneOe,
   // element selects
   input  wire logic                       rxElementSelectHi,
   input  wire logic                       rxElementSelectLo,
   input  wire logic                       txElementSelectHi,
   input  wire logic                       txElementSelectLo,
   // clocks or gates of the elements
   input  wire logic                       txClockOrGate,
   input  wire logic                       rxClockOrGate,
   // enables and feedback
   input  wire logic                       cardOutputEnable,
   input  wire logic                       backplaneEnableHighActive,
   input  wire logic                       backplaneEnableLowActive_n,
   input  wire logic                       feedbackSelect
);
   import rbt_pkg::*;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   rbt_mode_e         txMode;
   rbt_mode_e         rxMode;
   logic [DATA_W-1:0] txElemOut;
   logic [DATA_W-1:0] rxElemIn;
   logic [DATA_W-1:0] rxElemOut;
   logic              txCapture;
   logic              rxCapture;
   logic [CTRL_W-1:0] ctrlBits;
   logic              countClear;
   logic [BUS_W-1:0]  statusWord;
   logic [BUS_W-1:0]  countWord;
   logic [CNT_W-1:0]  txCount_ff;
   logic [CNT_W-1:0]  rxCount_ff;
   logic [CNT_W-1:0]  nxt_txCount;
   logic [CNT_W-1:0]  nxt_rxCount;

   // each direction decodes its own select pair
   assign txMode = rbt_decode_mode(txElementSelectHi, txElementSelectLo);
   assign rxMode = rbt_decode_mode(rxElementSelectHi, rxElementSelectLo);

   // feedback taps the transmit element before its inverter
   assign rxElemIn = feedbackSelect ? txElemOut : backplaneIn;

   rbt_elem u_txElem (
      .ref_clk      (ref_clk),
      .sys_rst      (sys_rst),
      .mode         (txMode),
      .gateIn       (txClockOrGate),
      .dataIn       (cardSideInput),
      .elemOut      (txElemOut),
      .capturePulse (txCapture)
   );

   rbt_elem u_rxElem (
      .ref_clk      (ref_clk),
      .sys_rst      (sys_rst),
      .mode         (rxMode),
      .gateIn       (rxClockOrGate),
      .dataIn       (rxElemIn),
      .elemOut      (rxElemOut),
      .capturePulse (rxCapture)
   );

   // outputs are combinational so buffer mode adds no clock of latency
   assign backplaneOut = ~txElemOut;
   assign cardSideOutput = ~rxElemOut;
   // enables only gate drivers; elements keep running underneath
   assign backplaneOe = backplaneEnableHighActive & ~backplaneEnableLowActive_n
                        & ~ctrlBits[CTRL_BP_RELEASE_BIT];
   assign cardSideOutputOe = cardOutputEnable & ~ctrlBits[CTRL_CARD_OFF_BIT];

   // status snapshot of both elements and the pin controls
   always_comb
   begin
      statusWord                                    = '0;
      statusWord[ST_TX_LSB +: DATA_W]               = txElemOut;
      statusWord[ST_RX_LSB +: DATA_W]               = rxElemOut;
      statusWord[ST_TXMODE_LSB +: $bits(rbt_mode_e)] = txMode;
      statusWord[ST_RXMODE_LSB +: $bits(rbt_mode_e)] = rxMode;
      statusWord[ST_FB_BIT]                         = feedbackSelect;
      statusWord[ST_CARDOE_BIT]                     = cardSideOutputOe;
      statusWord[ST_BPOE_BIT]                       = backplaneOe;
   end

   assign countWord = {rxCount_ff, txCount_ff};

   // a capture in the clearing cycle counts as the first one
   function automatic logic [CNT_W-1:0] rbt_next_count(input logic [CNT_W-1:0] cnt,
                                                       input logic             clr,
                                                       input logic             hit);
      logic [CNT_W-1:0] inc;
      inc = {{(CNT_W-1){1'b0}}, hit};
      if (clr)
         rbt_next_count = inc;
      else
         rbt_next_count = CNT_W'(cnt + inc);
   endfunction : rbt_next_count

   assign nxt_txCount = rbt_next_count(txCount_ff, countClear, txCapture);
   assign nxt_rxCount = rbt_next_count(rxCount_ff, countClear, rxCapture);

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         txCount_ff <= 16'h0;
         rxCount_ff <= 16'h0;
      end
      else
      begin
         txCount_ff <= nxt_txCount;
         rxCount_ff <= nxt_rxCount;
      end
   end

   rbt_regs u_regs (
      .ref_clk         (ref_clk),
      .sys_rst         (sys_rst),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .statusWord      (statusWord),
      .countWord       (countWord),
      .ctrlBits        (ctrlBits),
      .countClear      (countClear)
   );

   property p_tx_decode;
      (txElementSelectHi |-> txMode == RBT_LATCH)
      and ((!txElementSelectHi && txElementSelectLo) |-> txMode == RBT_FF)
      and ((!txElementSelectHi && !txElementSelectLo) |-> txMode == RBT_BUF);
   endproperty
   a_tx_decode: assert property (p_tx_decode) else $error("transmit select decoded wrongly");

   property p_rx_decode;
      (rxElementSelectHi |-> rxMode == RBT_LATCH)
      and ((!rxElementSelectHi && rxElementSelectLo) |-> rxMode == RBT_FF)
      and ((!rxElementSelectHi && !rxElementSelectLo) |-> rxMode == RBT_BUF);
   endproperty
   a_rx_decode: assert property (p_rx_decode) else $error("receive select decoded wrongly");

   property p_tx_buffer_path;
      (txMode == RBT_BUF) |-> (backplaneOut == ~cardSideInput);
   endproperty
   a_tx_buffer_path: assert property (p_tx_buffer_path) else $error("backplane not inverted card input");

   property p_fb_low_path;
      (!feedbackSelect && rxMode == RBT_BUF) |-> (cardSideOutput == ~backplaneIn);
   endproperty
   a_fb_low_path: assert property (p_fb_low_path) else $error("card output not inverted backplane");

   property p_fb_high_path;
      (feedbackSelect && rxMode == RBT_BUF) |-> (cardSideOutput == backplaneOut);
   endproperty
   a_fb_high_path: assert property (p_fb_high_path) else $error("feedback path not pre-inversion");

   property p_rx_ff_loop;
      (rxMode == RBT_FF && rxClockOrGate && !$past(rxClockOrGate) && !feedbackSelect)
      |=> (cardSideOutput == ~$past(backplaneIn));
   endproperty
   a_rx_ff_loop: assert property (p_rx_ff_loop) else $error("receive flip-flop captured wrong data");

   property p_card_enable;
      (cardSideOutputOe == (cardOutputEnable && !ctrlBits[CTRL_CARD_OFF_BIT]));
   endproperty
   a_card_enable: assert property (p_card_enable) else $error("card output enable wrong");

   property p_bp_enable;
      backplaneOe |-> (backplaneEnableHighActive && !backplaneEnableLowActive_n);
   endproperty
   a_bp_enable: assert property (p_bp_enable) else $error("backplane driven while disabled");

   property p_load_while_off;
      (!backplaneOe && txMode == RBT_LATCH && txClockOrGate) |-> (backplaneOut == ~cardSideInput);
   endproperty
   a_load_while_off: assert property (p_load_while_off) else $error("element stalled while disabled");

   property p_ctrl_write;
      (avs_write && !avs_waitrequest && avs_address == CTRL_OFS)
      |=> (ctrlBits == $past(avs_writedata[CTRL_W-1:0]));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write not applied");

   property p_wait_one;
      ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest held too long");

   // top-level data path and output enable checks
   property p_tx_ff_out;
      (txMode == RBT_FF && txCapture)
      |=> (txMode != RBT_FF || backplaneOut == ~$past(cardSideInput));
   endproperty
   a_tx_ff_out: assert property (p_tx_ff_out) else $error("transmit flip-flop output wrong");

   property p_tx_ff_hold;
      (txMode == RBT_FF && !txCapture) ##1 (txMode == RBT_FF) |-> $stable(backplaneOut);
   endproperty
   a_tx_ff_hold: assert property (p_tx_ff_hold) else $error("transmit flip-flop output moved");

   property p_rx_ff_hold;
      (rxMode == RBT_FF && !rxCapture) ##1 (rxMode == RBT_FF) |-> $stable(cardSideOutput);
   endproperty
   a_rx_ff_hold: assert property (p_rx_ff_hold) else $error("receive flip-flop output moved");

   property p_tx_latch_open;
      (txMode == RBT_LATCH && txClockOrGate) |-> (backplaneOut == ~cardSideInput);
   endproperty
   a_tx_latch_open: assert property (p_tx_latch_open) else $error("transmit latch not transparent");

   property p_rx_latch_fb;
      (rxMode == RBT_LATCH && rxClockOrGate && feedbackSelect) |-> (cardSideOutput == backplaneOut);
   endproperty
   a_rx_latch_fb: assert property (p_rx_latch_fb) else $error("open receive latch missed feedback");

   property p_bp_enable_on;
      (backplaneEnableHighActive && !backplaneEnableLowActive_n && !ctrlBits[CTRL_BP_RELEASE_BIT])
      |-> backplaneOe;
   endproperty
   a_bp_enable_on: assert property (p_bp_enable_on) else $error("backplane not driven while enabled");

   property p_bp_release;
      ctrlBits[CTRL_BP_RELEASE_BIT] |-> !backplaneOe;
   endproperty
   a_bp_release: assert property (p_bp_release) else $error("backplane driven while released");

   property p_card_off;
      ctrlBits[CTRL_CARD_OFF_BIT] |-> !cardSideOutputOe;
   endproperty
   a_card_off: assert property (p_card_off) else $error("card output driven while switched off");

   // capture counters, wait state and register reads
   property p_count_clear;
      (countClear && !txCapture && !rxCapture) |=> (countWord == 32'h0);
   endproperty
   a_count_clear: assert property (p_count_clear) else $error("capture counters not cleared");

   property p_tx_count_step;
      (!countClear && txCapture) |=> (txCount_ff == $past(txCount_ff) + 16'h1);
   endproperty
   a_tx_count_step: assert property (p_tx_count_step) else $error("transmit capture not counted");

   property p_rx_count_step;
      (!countClear && rxCapture) |=> (rxCount_ff == $past(rxCount_ff) + 16'h1);
   endproperty
   a_rx_count_step: assert property (p_rx_count_step) else $error("receive capture not counted");

   property p_wait_first;
      ((avs_read || avs_write) && !$past(avs_read || avs_write)) |-> avs_waitrequest;
   endproperty
   a_wait_first: assert property (p_wait_first) else $error("new request answered without wait state");

   property p_read_ctrl;
      (avs_read && !avs_waitrequest && avs_address == CTRL_OFS)
      |-> (avs_readdata == BUS_W'($past(ctrlBits)));
   endproperty
   a_read_ctrl: assert property (p_read_ctrl) else $error("control read returned wrong value");

   property p_read_status;
      (avs_read && !avs_waitrequest && avs_address == STATUS_OFS)
      |-> (avs_readdata == $past(statusWord));
   endproperty
   a_read_status: assert property (p_read_status) else $error("status read returned wrong value");

   property p_read_unmapped;
      (avs_read && !avs_waitrequest && avs_address != CTRL_OFS
       && avs_address != STATUS_OFS && avs_address != COUNT_OFS)
      |-> (avs_readdata == 32'h0);
   endproperty
   a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");
endmodule : rbt_top

// ===== test/rbt_backplane_model.sv
// backplane bus model: wired-and of the design and one other card, terminated high
`timescale 1ns/1ps
module rbt_backplane_model (
   // design side
   input  wire logic [rbt_pkg::DATA_W-1:0] dutDrive,
   input  wire logic                       dutOe,
   // another card on the bus
   input  wire logic [rbt_pkg::DATA_W-1:0] otherDrive,
   input  wire logic                       otherOe,
   // resolved level
   output logic      [rbt_pkg::DATA_W-1:0] busLevel
);
   import rbt_pkg::*;
   // released lines go to the termination level, never keep the last value
   wire logic [DATA_W-1:0] dutLevel   = dutOe ? dutDrive : 8'hFF;
   wire logic [DATA_W-1:0] otherLevel = otherOe ? otherDrive : 8'hFF;
   assign busLevel = dutLevel & otherLevel;
endmodule : rbt_backplane_model

// ===== test/rbt_top_tb_top.sv
// self-checking bench for the registered transceiver
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %0t mismatch", $time); end end
module rbt_top_tb_top;
   import rbt_pkg::*;
   typedef struct packed {
      logic fb, cOe, hi, loN;
      logic [7:0] cin;
      logic oOe;
      logic [7:0] oVal;
      logic xBpOe, xCOe;
      logic [7:0] xBp, xCard;
   } rbt_row_s;
   logic ref_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, cardSideOutputOe;
   logic [ADDR_W-1:0] avs_address = 4'h0;
   logic [BUS_W-1:0] avs_writedata = 32'h0, avs_readdata, rdat;
   logic [DATA_W-1:0] cardSideInput = 8'h00, cardSideOutput, backplaneIn, backplaneOut, otherDrive = 8'h00;
   logic backplaneOe, otherOe = 1'b0, rxElementSelectHi = 1'b0, rxElementSelectLo = 1'b0;
   logic txElementSelectHi = 1'b0, txElementSelectLo = 1'b0, txClockOrGate = 1'b0, rxClockOrGate = 1'b0;
   logic cardOutputEnable = 1'b1, backplaneEnableHighActive = 1'b1, backplaneEnableLowActive_n = 1'b0;
   logic feedbackSelect = 1'b0;
   int num_errors = 0, checks = 0;
   rbt_row_s rows [6] = '{
      '{1'b0, 1'b1, 1'b1, 1'b0, 8'hA5, 1'b0, 8'h00, 1'b1, 1'b1, 8'h5A, 8'hA5},
      '{1'b0, 1'b1, 1'b0, 1'b0, 8'h0F, 1'b1, 8'h3C, 1'b0, 1'b1, 8'hF0, 8'hC3},
      '{1'b0, 1'b1, 1'b1, 1'b1, 8'h81, 1'b0, 8'h00, 1'b0, 1'b1, 8'h7E, 8'h00},
      '{1'b0, 1'b0, 1'b0, 1'b1, 8'h42, 1'b1, 8'h99, 1'b0, 1'b0, 8'hBD, 8'h66},
      '{1'b1, 1'b1, 1'b1, 1'b0, 8'h96, 1'b1, 8'h00, 1'b1, 1'b1, 8'h69, 8'h69},
      '{1'b0, 1'b1, 1'b1, 1'b0, 8'hF0, 1'b1, 8'h3C, 1'b1, 1'b1, 8'h0F, 8'hF3}};

   rbt_top dut (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .cardSideInput, .cardSideOutput, .cardSideOutputOe, .backplaneIn, .backplaneOut,
      .backplaneOe, .rxElementSelectHi, .rxElementSelectLo, .txElementSelectHi, .txElementSelectLo,
      .txClockOrGate, .rxClockOrGate, .cardOutputEnable, .backplaneEnableHighActive,
      .backplaneEnableLowActive_n, .feedbackSelect);
   rbt_backplane_model bus (.dutDrive(backplaneOut), .dutOe(backplaneOe), .otherDrive(otherDrive),
      .otherOe(otherOe), .busLevel(backplaneIn));

   initial
   begin
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   // master holds the request until the edge that sees waitrequest low
   task automatic bus_xfer(input logic isWr, input logic [ADDR_W-1:0] adr, input logic [BUS_W-1:0] wd);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      @(posedge ref_clk);
      avs_address <= adr;
      avs_writedata <= wd;
      avs_read <= !isWr;
      avs_write <= isWr;
      while (!done && n < 20)
      begin
         #1;
         done = (avs_waitrequest === 1'b0);
         rdat = avs_readdata;
         @(posedge ref_clk);
         n++;
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (!done)
      begin
         num_errors++;
         $display("[ERR] %0t bus wait ran out", $time);
         finish_test();
      end
   endtask : bus_xfer

   // capture edge is the one that sees the gate high after a low
   task automatic gate_pulse(input logic isRx);
      @(posedge ref_clk);
      if (isRx) rxClockOrGate <= 1'b0; else txClockOrGate <= 1'b0;
      @(posedge ref_clk);
      if (isRx) rxClockOrGate <= 1'b1; else txClockOrGate <= 1'b1;
      @(posedge ref_clk);
      if (isRx) rxClockOrGate <= 1'b0; else txClockOrGate <= 1'b0;
      #1;
   endtask : gate_pulse

   initial
   begin
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      bus_xfer(1'b0, CTRL_OFS, 32'h0);
      `CHK(rdat, 32'h0)
      $display("reset defaults done");
      foreach (rows[i])
      begin
         @(posedge ref_clk);
         {feedbackSelect, cardOutputEnable, backplaneEnableHighActive, backplaneEnableLowActive_n} <=
            {rows[i].fb, rows[i].cOe, rows[i].hi, rows[i].loN};
         cardSideInput <= rows[i].cin;
         otherOe <= rows[i].oOe;
         otherDrive <= rows[i].oVal;
         #1;
         `CHK(backplaneOe, rows[i].xBpOe)
         `CHK(cardSideOutputOe, rows[i].xCOe)
         `CHK(backplaneOut, rows[i].xBp)
         `CHK(cardSideOutput, rows[i].xCard)
      end
      $display("buffer table done");
      @(posedge ref_clk);
      {txElementSelectHi, txElementSelectLo, backplaneEnableHighActive, feedbackSelect} <= 4'h4;
      cardSideInput <= 8'h3C;
      otherOe <= 1'b0;
      bus_xfer(1'b1, COUNT_OFS, 32'h0);
      gate_pulse(1'b0);
      `CHK(backplaneOut, 8'hC3)
      @(posedge ref_clk);
      cardSideInput <= 8'h55;
      #1;
      `CHK(backplaneOut, 8'hC3)
      bus_xfer(1'b0, COUNT_OFS, 32'h0);
      `CHK(rdat, 32'h1)
      bus_xfer(1'b0, STATUS_OFS, 32'h0);
      `CHK(rdat[22:16], 7'h21)
      $display("transmit flip-flop done");
      @(posedge ref_clk);
      rxElementSelectLo <= 1'b1;
      otherOe <= 1'b1;
      otherDrive <= 8'h5A;
      gate_pulse(1'b1);
      `CHK(cardSideOutput, 8'hA5)
      @(posedge ref_clk);
      otherDrive <= 8'h00;
      gate_pulse(1'b0);
      `CHK(cardSideOutput, 8'hA5)
      bus_xfer(1'b0, COUNT_OFS, 32'h0);
      `CHK(rdat, 32'h0001_0002)
      $display("receive flip-flop done");
      @(posedge ref_clk);
      {txElementSelectHi, txElementSelectLo, txClockOrGate} <= 3'h5;
      cardSideInput <= 8'h11;
      #1;
      `CHK(backplaneOut, 8'hEE)
      @(posedge ref_clk);
      cardSideInput <= 8'h22;
      #1;
      `CHK(backplaneOut, 8'hDD)
      @(posedge ref_clk);
      txClockOrGate <= 1'b0;
      @(posedge ref_clk);
      cardSideInput <= 8'h44;
      txElementSelectLo <= 1'b1;
      #1;
      `CHK(backplaneOut, 8'hDD)
      @(posedge ref_clk);
      {rxElementSelectHi, rxElementSelectLo, feedbackSelect, rxClockOrGate} <= 4'hB;
      #1;
      `CHK(cardSideOutput, 8'hDD)
      @(posedge ref_clk);
      {feedbackSelect, rxClockOrGate} <= 2'h0;
      #1;
      `CHK(cardSideOutput, 8'hDD)
      $display("latch and feedback done");
      @(posedge ref_clk);
      backplaneEnableHighActive <= 1'b1;
      bus_xfer(1'b1, CTRL_OFS, 32'h3);
      #1;
      `CHK(backplaneOe, 1'b0)
      `CHK(cardSideOutputOe, 1'b0)
      bus_xfer(1'b0, CTRL_OFS, 32'h0);
      `CHK(rdat, 32'h3)
      bus_xfer(1'b1, 4'hC, 32'hFFFF_FFFF);
      bus_xfer(1'b0, 4'hC, 32'h0);
      `CHK(rdat, 32'h0)
      bus_xfer(1'b1, CTRL_OFS, 32'h0);
      #1;
      `CHK(backplaneOe, 1'b1)
      $display("register access done");
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      #1;
      // element storage survives the reset; control registers and capture counters clear
      `CHK(backplaneOut, 8'hDD)
      bus_xfer(1'b0, CTRL_OFS, 32'h0);
      `CHK(rdat, 32'h0)
      $display("mid-run reset done");
      finish_test();
   end
endmodule : rbt_top_tb_top
